/* hdl/hfcs_pkg.sv */
// Shared constants and types of the hazard-free clock switch
package hfcs_pkg;
    // Input synchroniser depth and start-up settling
    localparam int unsigned SYNC_STAGES = 3;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;
    // New-clock rising edges that must pass before the output follows it
    localparam logic [1:0] NEW_RISES_NEEDED = 2'h2;
    // Number of clock options on the pins
    localparam int unsigned OPT_COUNT = 4;
    localparam int unsigned OPT_IDX_W = 2;
    // Option indices presented on each input, per value of the pair field
    localparam logic [1:0] PAIR0_A = 2'h0;
    localparam logic [1:0] PAIR0_B = 2'h1;
    localparam logic [1:0] PAIR1_A = 2'h0;
    localparam logic [1:0] PAIR1_B = 2'h2;
    localparam logic [1:0] PAIR2_A = 2'h1;
    localparam logic [1:0] PAIR2_B = 2'h2;
    localparam logic [1:0] PAIR3_A = 2'h2;
    localparam logic [1:0] PAIR3_B = 2'h3;
    // Select bit that names the source at take-over: 0 is input a, 1 is input b; any later select change toggles the source
    localparam int unsigned SEL_SRC_BIT = 0;
    // Reset values
    localparam logic RST_OUT = 1'b0;
    localparam logic RST_SRC = 1'b0;
    localparam logic [1:0] RST_SEL = 2'h0;

    typedef enum logic [1:0] {
        HFCS_SETTLE = 2'b00,
        HFCS_FOLLOW = 2'b01,
        HFCS_FINISH_OLD = 2'b10,
        HFCS_WAIT_NEW = 2'b11
    } hfcs_state_t;

    // The two clocks presented to the switch after pair selection
    typedef struct packed {
        logic clk_a;
        logic clk_b;
    } hfcs_pair_t;
endpackage

/* hdl/hfcs_switch.sv */
// Glitch-free two-source clock switch, oversampled on the system clock
// Behaviour
// - Output passes exactly one of two inputs
// - Pair field picks which two options appear
// - Select value change starts a handover
// - Old clock gives one final complete pulse
// - Output low until new clock's second rise
// - Then output follows new clock continuously
`timescale 1ns/1ps
module hfcs_switch #(
    parameter int unsigned OPT_W = hfcs_pkg::OPT_COUNT
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [OPT_W-1:0] clock_option_in,
    input wire logic [1:0] source_pair_config_in,
    input wire logic [1:0] source_select_in,
    output logic switched_clock_out,
    output logic busy_out
);
    localparam int unsigned SYNC_W = OPT_W + 2;

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] sync3_ff;
    logic [SYNC_W-1:0] filt_ff;
    logic [OPT_W-1:0] opt_filt;
    logic [1:0] sel_filt;
    logic [SYNC_W-1:0] nxt_filt;
    logic [1:0] sel_next;
    hfcs_pkg::hfcs_pair_t pair;
    hfcs_pkg::hfcs_pair_t pair_prev_ff;
    hfcs_pkg::hfcs_state_t state_ff;
    hfcs_pkg::hfcs_state_t nxt_state;
    logic cur_src_ff;
    logic nxt_cur_src;
    logic [1:0] sel_last_ff;
    logic [1:0] settle_cnt_ff;
    logic [1:0] rise_cnt_ff;
    logic old_rise_seen_ff;
    logic switched_clock_ff;
    logic nxt_switched_clock;
    logic old_clk;
    logic old_prev;
    logic new_clk;
    logic new_prev;
    logic old_rise;
    logic old_fall;
    logic new_rise;
    logic request;

    // Select and option pins cross into the system clock: three stages per bit
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= {source_select_in, clock_option_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // A change counts only once stages two and three agree
    always_comb begin
        nxt_filt = (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & filt_ff);
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            filt_ff <= '0;
        end else begin
            filt_ff <= nxt_filt;
        end
    end

    assign opt_filt = filt_ff[OPT_W-1:0];
    assign sel_filt = filt_ff[SYNC_W-1:OPT_W];
    // Take-over reads the value the filter loads at that same edge,
    // so a select held through reset never looks like a request
    assign sel_next = nxt_filt[SYNC_W-1:OPT_W];

    always_comb begin
        unique case (source_pair_config_in)
            2'h0: pair = '{clk_a: opt_filt[hfcs_pkg::PAIR0_A], clk_b: opt_filt[hfcs_pkg::PAIR0_B]};
            2'h1: pair = '{clk_a: opt_filt[hfcs_pkg::PAIR1_A], clk_b: opt_filt[hfcs_pkg::PAIR1_B]};
            2'h2: pair = '{clk_a: opt_filt[hfcs_pkg::PAIR2_A], clk_b: opt_filt[hfcs_pkg::PAIR2_B]};
            2'h3: pair = '{clk_a: opt_filt[hfcs_pkg::PAIR3_A], clk_b: opt_filt[hfcs_pkg::PAIR3_B]};
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            pair_prev_ff <= '0;
        end else begin
            pair_prev_ff <= pair;
        end
    end

    // Old and new source chosen by one bit
    assign old_clk = cur_src_ff ? pair.clk_b : pair.clk_a;
    assign old_prev = cur_src_ff ? pair_prev_ff.clk_b : pair_prev_ff.clk_a;
    assign new_clk = cur_src_ff ? pair.clk_a : pair.clk_b;
    assign new_prev = cur_src_ff ? pair_prev_ff.clk_a : pair_prev_ff.clk_b;
    assign old_rise = old_clk & ~old_prev;
    assign old_fall = ~old_clk & old_prev;
    assign new_rise = new_clk & ~new_prev;
    // Changes during a handover are compared again back in follow
    // Any change of select value
    assign request = (state_ff == hfcs_pkg::HFCS_FOLLOW) && (sel_filt != sel_last_ff);

    always_comb begin
        nxt_state = state_ff;
        nxt_cur_src = cur_src_ff;
        nxt_switched_clock = hfcs_pkg::RST_OUT;
        unique case (state_ff)
            hfcs_pkg::HFCS_SETTLE: begin
                if (settle_cnt_ff == hfcs_pkg::SETTLE_CYCLES) begin
                    nxt_state = hfcs_pkg::HFCS_FOLLOW;
                    nxt_cur_src = sel_next[hfcs_pkg::SEL_SRC_BIT];
                end
            end
            hfcs_pkg::HFCS_FOLLOW: begin
                nxt_switched_clock = old_clk;
                if (request) begin
                    nxt_state = hfcs_pkg::HFCS_FINISH_OLD;
                end
            end
            hfcs_pkg::HFCS_FINISH_OLD: begin
                // Last full pulse of old clock
                nxt_switched_clock = old_clk;
                if (old_rise_seen_ff && old_fall) begin
                    nxt_state = hfcs_pkg::HFCS_WAIT_NEW;
                    nxt_switched_clock = 1'b0;
                end
            end
            hfcs_pkg::HFCS_WAIT_NEW: begin
                if (new_rise && (rise_cnt_ff == hfcs_pkg::NEW_RISES_NEEDED - 2'h1)) begin
                    nxt_state = hfcs_pkg::HFCS_FOLLOW;
                    nxt_cur_src = ~cur_src_ff;
                    nxt_switched_clock = new_clk;
                end
            end
        endcase
    end

    // Each register of the sequencer has its own process
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_ff <= hfcs_pkg::HFCS_SETTLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            cur_src_ff <= hfcs_pkg::RST_SRC;
        end else begin
            cur_src_ff <= nxt_cur_src;
        end
    end

    // Output is a flop so no pin-to-net path can carry a runt
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            switched_clock_ff <= hfcs_pkg::RST_OUT;
        end else begin
            switched_clock_ff <= nxt_switched_clock;
        end
    end

    // Settle counter lets the select synchroniser fill before it is trusted
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            settle_cnt_ff <= '0;
        end else if (state_ff == hfcs_pkg::HFCS_SETTLE && settle_cnt_ff != hfcs_pkg::SETTLE_CYCLES) begin
            settle_cnt_ff <= settle_cnt_ff + 2'h1;
        end
    end

    // Select value remembered at take-over and at each request
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sel_last_ff <= hfcs_pkg::RST_SEL;
        end else if (state_ff == hfcs_pkg::HFCS_SETTLE) begin
            sel_last_ff <= sel_next;
        end else if (request) begin
            sel_last_ff <= sel_filt;
        end
    end

    // A pulse already high at the request is not counted as the last one;
    // a rise in the very cycle of the request opens the last pulse
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            old_rise_seen_ff <= 1'b0;
        end else if (old_rise && (request || state_ff == hfcs_pkg::HFCS_FINISH_OLD)) begin
            old_rise_seen_ff <= 1'b1;
        end else if (state_ff != hfcs_pkg::HFCS_FINISH_OLD) begin
            old_rise_seen_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            rise_cnt_ff <= '0;
        end else if (state_ff != hfcs_pkg::HFCS_WAIT_NEW) begin
            rise_cnt_ff <= '0;
        end else if (new_rise) begin
            rise_cnt_ff <= rise_cnt_ff + 2'h1;
        end
    end

    assign switched_clock_out = switched_clock_ff;
    assign busy_out = (state_ff != hfcs_pkg::HFCS_FOLLOW);
endmodule // hfcs_switch

/* bench/hfcs_switch_props.sv */
// Port checker for the hazard-free clock switch
`timescale 1ns/1ps
module hfcs_switch_props #(
    parameter int unsigned OPT_W = hfcs_pkg::OPT_COUNT
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [OPT_W-1:0] clock_option_in,
    input wire logic [1:0] source_pair_config_in,
    input wire logic [1:0] source_select_in,
    input wire logic switched_clock_out,
    input wire logic busy_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_request;
        !busy_out && $changed(source_select_in);
    endsequence
    sequence s_new_takes;
        !$past(switched_clock_out) && switched_clock_out;
    endsequence
    a_settle_direct: assert property ($rose(reset_n_in) |-> ##[1:4] !busy_out)
        else $error("settle too long");
    a_request_seen: assert property (s_request |-> ##[1:8] busy_out)
        else $error("request not taken");
    a_no_spurious: assert property ((!busy_out && $stable(source_select_in))[*8] |=> !busy_out)
        else $error("handover without request");
    a_handover_bound: assert property ($rose(busy_out) |-> ##[1:400] !busy_out)
        else $error("handover never ends");
    a_high_whole: assert property ($rose(switched_clock_out) |=> switched_clock_out)
        else $error("runt high pulse");
    a_low_whole: assert property ($fell(switched_clock_out) |=> !switched_clock_out)
        else $error("runt low pulse");
    a_new_starts: assert property ($fell(busy_out) && $past(reset_n_in, 6) |-> s_new_takes)
        else $error("new clock not taken on rise");
endmodule // hfcs_switch_props
bind hfcs_switch hfcs_switch_props #(.OPT_W(OPT_W)) u_hfcs_switch_props (.*);

/* bench/hfcs_clk_src.sv */
// Four free-running source clocks, half periods of 3 to 6 system cycles
`timescale 1ns/1ps
module hfcs_clk_src (
    input wire logic clk_sys_in,
    output logic [3:0] clock_option_out
);
    logic [3:0] cnt_ff [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
    initial clock_option_out = 4'h0;
    // Distinct periods let the bench tell which option is passed
    always @(posedge clk_sys_in) begin
        for (int i = 0; i < 4; i++) begin
            cnt_ff[i] <= (cnt_ff[i] == 4'(i + 2)) ? 4'h0 : cnt_ff[i] + 4'h1;
            if (cnt_ff[i] == 4'(i + 2)) clock_option_out[i] <= ~clock_option_out[i];
        end
    end
endmodule // hfcs_clk_src

/* bench/tb_top.sv */
// Self-checking bench for the hazard-free clock switch
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [3:0] clock_option_in;
    logic [1:0] source_pair_config_in = 2'h0;
    logic [1:0] source_select_in = 2'h0;
    logic switched_clock_out;
    logic busy_out;
    int n_errors = 0;
    int samples_checked = 0;
    initial forever #12.5 clk_sys_in = ~clk_sys_in;
    hfcs_clk_src u_hfcs_clk_src (.clk_sys_in(clk_sys_in), .clock_option_out(clock_option_in));
    hfcs_switch u_hfcs_switch (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .clock_option_in(clock_option_in),
        .source_pair_config_in(source_pair_config_in), .source_select_in(source_select_in),
        .switched_clock_out(switched_clock_out), .busy_out(busy_out));
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Period of an option with index o is 2*(o+3) system cycles
    function automatic logic [7:0] per_of(logic [1:0] cfg, logic b);
        logic [1:0] o;
        case (cfg)
            2'h0: o = b ? hfcs_pkg::PAIR0_B : hfcs_pkg::PAIR0_A;
            2'h1: o = b ? hfcs_pkg::PAIR1_B : hfcs_pkg::PAIR1_A;
            2'h2: o = b ? hfcs_pkg::PAIR2_B : hfcs_pkg::PAIR2_A;
            default: o = b ? hfcs_pkg::PAIR3_B : hfcs_pkg::PAIR3_A;
        endcase
        return {5'h0, o, 1'b0} + 8'h6;
    endfunction
    task automatic period(output logic [7:0] p);
        int c;
        logic prev;
        c = -1;
        prev = 1'b1;
        p = 8'h0;
        for (int i = 0; i < 80 && p == 8'h0; i++) begin
            @(negedge clk_sys_in);
            if (c >= 0) c++;
            if (switched_clock_out === 1'b1 && prev === 1'b0) begin
                if (c > 0) p = 8'(c);
                c = 0;
            end
            prev = switched_clock_out;
        end
    endtask
    task automatic start(logic [1:0] cfg, logic [1:0] sel);
        @(posedge clk_sys_in);
        reset_n_in <= 1'b0;
        source_pair_config_in <= cfg;
        source_select_in <= sel;
        repeat (20) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (6) @(negedge clk_sys_in);
    endtask
    task automatic test_pairs();
        logic [7:0] p;
        for (int k = 0; k < 8; k++) begin
            start(2'(k >> 1), 2'(k));
            check("settle busy", 8'h0, {7'h0, busy_out});
            period(p);
            check("pair period", per_of(2'(k >> 1), k[0]), p);
        end
        $display("test_pairs done");
    endtask
    task automatic handover(logic [1:0] sel, logic [7:0] old_p, logic [7:0] exp);
        int gap;
        int hi;
        int last_hi;
        logic [7:0] p;
        gap = 0;
        hi = 0;
        last_hi = 0;
        @(posedge clk_sys_in);
        source_select_in <= sel;
        for (int i = 0; i < 300 && (i < 8 || busy_out === 1'b1); i++) begin
            @(negedge clk_sys_in);
            if (i == 7) check("busy on request", 8'h1, {7'h0, busy_out});
            if (busy_out === 1'b1) gap = switched_clock_out ? 0 : gap + 1;
            if (switched_clock_out === 1'b1) begin
                hi++;
            end else if (hi > 0) begin
                last_hi = hi;
                hi = 0;
            end
        end
        check("last old pulse", old_p >> 1, 8'(last_hi));
        check("low gap", 8'h1, {7'h0, gap >= int'(exp)});
        period(p);
        check("new period", exp, p);
    endtask
    task automatic test_handover();
        start(2'h3, 2'h0);
        handover(2'h1, per_of(2'h3, 1'b0), per_of(2'h3, 1'b1));
        // Return handover once the first has ended and its new period has been measured
        handover(2'h0, per_of(2'h3, 1'b1), per_of(2'h3, 1'b0));
        $display("test_handover done");
    endtask
    // A change arriving mid-handover is held, then served; 1 to 2 flips both bits
    task automatic test_requeue();
        logic [7:0] p;
        start(2'h0, 2'h0);
        @(posedge clk_sys_in);
        source_select_in <= 2'h1;
        repeat (8) @(posedge clk_sys_in);
        source_select_in <= 2'h2;
        for (int i = 0; i < 300 && busy_out !== 1'b0; i++) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        check("busy on held request", 8'h1, {7'h0, busy_out});
        for (int i = 0; i < 300 && busy_out !== 1'b0; i++) @(negedge clk_sys_in);
        period(p);
        check("held request period", per_of(2'h0, 1'b0), p);
        $display("test_requeue done");
    endtask
    initial begin
        test_pairs();
        test_handover();
        test_requeue();
        close_out();
    end
    initial begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        close_out();
    end
endmodule // tb_top
